// ---- core/comparator_event_irq_status_regs.sv ----
// Chosen here: the APB slave port.
`timescale 1ns/10ps
`include "cmp_regs_defines.svh"
// Operation
// RQ1 - Comparator start bit set: any incoming event starts a comparison; clear: none.
// RQ2 - Any of several incoming events triggers the action; source not reported.
// RQ3 - Window event produced only while window event output enable is one.
// RQ4 - Comparator event produced only while its event output enable is one.
// RQ5 - Event control writes accepted only while the comparator unit is disabled.
// RQ6 - Enable-clear reads current enables; writing one disables; zero no effect.
// RQ7 - Enable-clear and enable-set share one set of enable bits.
// RQ8 - Enable-set window bit: one enables, zero no effect, reads enable state.
// RQ9 - Enable-set comparator bit: one enables that interrupt, zero leaves it.
// RQ10 - Window flag set per window selection; interrupts when flag and enable both one.
// RQ11 - Writing one clears window flag; zero leaves it.
// RQ12 - Comparator flag set per its selection; interrupts when flag and enable set.
// RQ13 - Writing one clears comparator flag; zero leaves it; reads show status.
// RQ14 - Unimplemented comparator flag bits read as zero.
// RQ15 - Window position field: 0 above, 1 inside, 2 below, 3 reserved.
// RQ16 - Comparator state bit shows comparator output, valid while ready is one.
// RQ17 - Ready bit set while comparator output is ready, clear otherwise.
// RQ18 - Window selection: 0 above, 1 inside, 2 below, 3 outside.
// RQ19 - Single interrupt output is OR of every flag ANDed with its enable.
module comparator_event_irq_status_regs
	import cmp_regs_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] start_event_in,
	input wire logic [1:0] cmp_output_state,
	input wire logic [1:0] cmp_output_valid,
	output logic [1:0] cmp_start,
	output logic [1:0] cmp_event_out,
	output logic window_event_out,
	output logic unit_enable,
	output logic irq
);

	regs_t state_reg;
	regs_t state_next;

	function automatic logic [7:0] byte_addr(input logic [7:0] idx);
		byte_addr = {idx[5:0], 2'b00};
	endfunction

	// Flag condition for one comparator from its selection
	function automatic logic cmp_hit(input cmp_irq_sel_t sel, input logic out_now,
		input logic out_prev, input logic rdy_now, input logic rdy_prev);
		logic both;
		both = rdy_now & rdy_prev;
		case (sel)
			CMP_IRQ_TOGGLE: cmp_hit = both & (out_now ^ out_prev);
			CMP_IRQ_RISING: cmp_hit = both & out_now & ~out_prev;
			CMP_IRQ_FALLING: cmp_hit = both & ~out_now & out_prev;
			CMP_IRQ_DONE: cmp_hit = rdy_now & ~rdy_prev;
			default: cmp_hit = 1'b0;
		endcase
	endfunction

	// Upper comparator is 0, lower comparator is 1
	function automatic win_code_t win_pos(input logic [1:0] outs);
		if (outs[0]) begin
			win_pos = WIN_ABOVE;
		end else if (outs[1]) begin
			win_pos = WIN_INSIDE;
		end else begin
			win_pos = WIN_BELOW;
		end
	endfunction

	logic [1:0] hit;
	logic access;
	logic wr;
	logic rd_setup;
	logic both_ready;
	logic win_hit;
	win_code_t pos;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_cmp
			assign hit[gi] = cmp_hit(cmp_irq_sel_t'(state_reg.cmp_sel[2*gi +: 2]),
				cmp_output_state[gi], state_reg.prev_out[gi],
				cmp_output_valid[gi], state_reg.prev_ready[gi]); // RQ12
		end
	endgenerate

	assign access = psel & penable & state_reg.pready;
	assign wr = access & pwrite;
	assign rd_setup = psel & ~penable & ~state_reg.pready;
	assign both_ready = &cmp_output_valid;
	assign pos = win_pos(cmp_output_state); // RQ15

	always_comb begin
		case (win_code_t'(state_reg.win_sel))
			WIN_ABOVE: win_hit = pos == WIN_ABOVE; // RQ18
			WIN_INSIDE: win_hit = pos == WIN_INSIDE;
			WIN_BELOW: win_hit = pos == WIN_BELOW;
			WIN_OUTSIDE: win_hit = pos != WIN_INSIDE;
			default: win_hit = 1'b0;
		endcase
		win_hit = win_hit & state_reg.win_en & both_ready;
	end

	always_comb begin
		logic [7:0] rd;
		logic [1:0] cmp_clr;
		logic win_clr;
		logic win_rise;
		rd = 8'h00;
		cmp_clr = 2'b00;
		win_clr = 1'b0;
		win_rise = win_hit & ~state_reg.prev_win_hit;
		state_next = state_reg;

		// Bus write side
		if (wr) begin
			if (paddr == byte_addr(`IDX_EVENT_CONTROL) && !state_reg.unit_en) begin // RQ5
				state_next.evt_start_en = pwdata[`EVC_START_LSB +: 2];
				state_next.win_evt_out_en = pwdata[`EVC_WIN_OUT_BIT];
				state_next.evt_out_en = pwdata[1:0];
			end
			if (paddr == byte_addr(`IDX_IRQ_ENABLE_CLEAR)) begin
				state_next.cmp_ien = state_reg.cmp_ien & ~pwdata[1:0]; // RQ6
				state_next.win_ien = state_reg.win_ien & ~pwdata[`BIT_WIN];
			end
			if (paddr == byte_addr(`IDX_IRQ_ENABLE_SET)) begin
				state_next.cmp_ien = state_reg.cmp_ien | pwdata[1:0]; // RQ9
				state_next.win_ien = state_reg.win_ien | pwdata[`BIT_WIN]; // RQ8
			end
			if (paddr == byte_addr(`IDX_IRQ_FLAGS)) begin
				cmp_clr = pwdata[1:0]; // RQ13
				win_clr = pwdata[`BIT_WIN]; // RQ11
			end
			if (paddr == byte_addr(`IDX_UNIT_CONFIG)) begin
				state_next.unit_en = pwdata[`CFG_ENABLE_BIT];
				state_next.win_en = pwdata[`CFG_WIN_EN_BIT];
				state_next.win_sel = pwdata[`CFG_WIN_SEL_LSB +: 2];
				state_next.cmp_sel = pwdata[`CFG_CMP_SEL_LSB +: 4];
			end
		end

		// Set wins over a simultaneous clear
		state_next.cmp_flag = (state_reg.cmp_flag & ~cmp_clr) | hit; // RQ12
		state_next.win_flag = (state_reg.win_flag & ~win_clr) | win_rise; // RQ10

		state_next.prev_out = cmp_output_state;
		state_next.prev_ready = cmp_output_valid;
		state_next.prev_win_hit = win_hit;
		state_next.start = state_reg.evt_start_en & {2{|start_event_in}}; // RQ1 RQ2
		state_next.evt_out = state_reg.evt_out_en & hit; // RQ4
		state_next.win_evt = state_reg.win_evt_out_en & win_rise; // RQ3
		state_next.irq = |(state_next.cmp_flag & state_next.cmp_ien)
			| (state_next.win_flag & state_next.win_ien); // RQ19

		// Read decode, captured in the setup cycle
		case (paddr)
			byte_addr(`IDX_EVENT_CONTROL): begin
				rd = {3'b000, state_reg.win_evt_out_en, 2'b00, state_reg.evt_out_en};
			end
			byte_addr(`IDX_IRQ_ENABLE_CLEAR), byte_addr(`IDX_IRQ_ENABLE_SET): begin
				rd = {3'b000, state_reg.win_ien, 2'b00, state_reg.cmp_ien}; // RQ7
			end
			byte_addr(`IDX_IRQ_FLAGS): begin
				rd = {3'b000, state_reg.win_flag, 2'b00, state_reg.cmp_flag}; // RQ14
			end
			byte_addr(`IDX_COMPARATOR_STATE): begin
				rd = {2'b00, state_reg.win_en ? pos : WIN_ABOVE, 2'b00, cmp_output_state}; // RQ16
			end
			byte_addr(`IDX_CMP_READY_STATUS): begin
				rd = {6'b000000, cmp_output_valid}; // RQ17
			end
			byte_addr(`IDX_UNIT_CONFIG): begin
				rd = {state_reg.cmp_sel, state_reg.win_sel, state_reg.win_en, state_reg.unit_en};
			end
			default: begin
				rd = 8'h00;
			end
		endcase

		state_next.pready = rd_setup;
		if (rd_setup) begin
			state_next.prdata = 32'h00000000;
			if (paddr == byte_addr(`IDX_EVENT_CONTROL)) begin
				state_next.prdata = {22'h0, state_reg.evt_start_en, rd};
			end else if (!pwrite) begin
				state_next.prdata = {24'h000000, rd};
			end
			state_next.pslverr = !(paddr == byte_addr(`IDX_EVENT_CONTROL)
				|| paddr == byte_addr(`IDX_IRQ_ENABLE_CLEAR)
				|| paddr == byte_addr(`IDX_IRQ_ENABLE_SET)
				|| paddr == byte_addr(`IDX_IRQ_FLAGS)
				|| paddr == byte_addr(`IDX_COMPARATOR_STATE)
				|| paddr == byte_addr(`IDX_CMP_READY_STATUS)
				|| paddr == byte_addr(`IDX_UNIT_CONFIG));
		end else if (access) begin
			state_next.pslverr = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign prdata = state_reg.prdata;
	assign pready = state_reg.pready;
	assign pslverr = state_reg.pslverr;
	assign cmp_start = state_reg.start;
	assign cmp_event_out = state_reg.evt_out;
	assign window_event_out = state_reg.win_evt;
	assign unit_enable = state_reg.unit_en;
	assign irq = state_reg.irq;

	// Checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_start_gated: assert property ( // RQ1
		##1 cmp_start == ($past(state_reg.evt_start_en) & {2{|$past(start_event_in)}}))
		else $error("comparison start does not follow event and start enable");

	a_start_blocked: assert property ( // RQ1
		(state_reg.evt_start_en == 2'b00) |=> cmp_start == 2'b00)
		else $error("comparison started while start enables are clear");

	a_win_evt_en: assert property ( // RQ3
		!state_reg.win_evt_out_en |=> !window_event_out)
		else $error("window event without its output enable");

	a_cmp_evt_en: assert property ( // RQ4
		(hit == 2'b00 || state_reg.evt_out_en == 2'b00) |=> cmp_event_out == 2'b00)
		else $error("comparator event without enable and cause");

	a_event_control_locked: assert property ( // RQ5
		state_reg.unit_en && wr && paddr == byte_addr(`IDX_EVENT_CONTROL)
		|=> $stable(state_reg.evt_out_en) && $stable(state_reg.evt_start_en))
		else $error("event control changed while unit enabled");

	a_enclr_clears: assert property ( // RQ6
		wr && paddr == byte_addr(`IDX_IRQ_ENABLE_CLEAR) && pwdata[`BIT_CMP0]
		|=> !state_reg.cmp_ien[0])
		else $error("enable clear did not disable comparator 0");

	a_enset_sets: assert property ( // RQ8
		wr && paddr == byte_addr(`IDX_IRQ_ENABLE_SET) && pwdata[`BIT_WIN]
		|=> state_reg.win_ien)
		else $error("enable set did not enable window interrupt");

	a_enset_keeps: assert property ( // RQ9
		wr && paddr == byte_addr(`IDX_IRQ_ENABLE_SET) && state_reg.cmp_ien[1]
		|=> state_reg.cmp_ien[1])
		else $error("enable set cleared a comparator enable");

	a_flag_sticky: assert property ( // RQ13
		state_reg.cmp_flag[0] && !(wr && paddr == byte_addr(`IDX_IRQ_FLAGS) && pwdata[0])
		|=> state_reg.cmp_flag[0])
		else $error("comparator flag dropped without a clear");

	a_win_clear: assert property ( // RQ11
		wr && paddr == byte_addr(`IDX_IRQ_FLAGS) && pwdata[`BIT_WIN] && !win_hit
		|=> !state_reg.win_flag)
		else $error("window flag not cleared by write of one");

	a_irq_or: assert property ( // RQ19
		irq == (|(state_reg.cmp_flag & state_reg.cmp_ien)
		| (state_reg.win_flag & state_reg.win_ien)))
		else $error("interrupt output differs from flag and enable");

	a_apb_answer: assert property (
		psel && !penable && !pready |=> pready ##1 !pready)
		else $error("bus answer not one cycle after setup");

	a_start_any: assert property ( // RQ2
		|start_event_in && state_reg.evt_start_en[1] |=> cmp_start[1])
		else $error("incoming event did not start comparator 1");

	a_win_evt_gen: assert property ( // RQ3
		win_hit && !state_reg.prev_win_hit && state_reg.win_evt_out_en |=> window_event_out)
		else $error("enabled window event not produced");

	a_evt_out_gen: assert property ( // RQ4
		hit[0] && state_reg.evt_out_en[0] |=> cmp_event_out[0])
		else $error("enabled comparator event not produced");

	a_enclr_win: assert property ( // RQ6
		wr && paddr == byte_addr(`IDX_IRQ_ENABLE_CLEAR) && pwdata[`BIT_WIN]
		|=> !state_reg.win_ien)
		else $error("enable clear did not disable window interrupt");

	a_enables_shared: assert property ( // RQ7
		rd_setup && !pwrite && (paddr == byte_addr(`IDX_IRQ_ENABLE_CLEAR)
		|| paddr == byte_addr(`IDX_IRQ_ENABLE_SET))
		|=> prdata[`BIT_WIN] == $past(state_reg.win_ien)
		&& prdata[1:0] == $past(state_reg.cmp_ien))
		else $error("enable registers do not show the shared enables");

	a_enset_cmp: assert property ( // RQ9
		wr && paddr == byte_addr(`IDX_IRQ_ENABLE_SET) && pwdata[`BIT_CMP1]
		|=> state_reg.cmp_ien[1])
		else $error("enable set did not enable comparator 1");

	a_win_flag_set: assert property ( // RQ10
		win_hit && !state_reg.prev_win_hit |=> state_reg.win_flag)
		else $error("window flag not set on entering the selected condition");

	a_win_irq: assert property ( // RQ10
		state_reg.win_flag && state_reg.win_ien |-> irq)
		else $error("window flag and enable without interrupt");

	a_win_sticky: assert property ( // RQ11
		state_reg.win_flag
		&& !(wr && paddr == byte_addr(`IDX_IRQ_FLAGS) && pwdata[`BIT_WIN])
		|=> state_reg.win_flag)
		else $error("window flag dropped without a clear");

	a_cmp_flag_set: assert property ( // RQ12
		hit[0] |=> state_reg.cmp_flag[0])
		else $error("comparator 0 flag not set by its condition");

	a_cmp_irq: assert property ( // RQ12
		state_reg.cmp_flag[1] && state_reg.cmp_ien[1] |-> irq)
		else $error("comparator flag and enable without interrupt");

	a_flag1_clear: assert property ( // RQ13
		wr && paddr == byte_addr(`IDX_IRQ_FLAGS) && pwdata[`BIT_CMP1] && !hit[1]
		|=> !state_reg.cmp_flag[1])
		else $error("comparator 1 flag not cleared by write of one");

	a_flag_unused: assert property ( // RQ14
		rd_setup && !pwrite && paddr == byte_addr(`IDX_IRQ_FLAGS)
		|=> prdata[3:2] == 2'b00 && prdata[31:5] == 27'h0)
		else $error("unused flag bits read as nonzero");

	a_pos_code: assert property ( // RQ15
		rd_setup && !pwrite && paddr == byte_addr(`IDX_COMPARATOR_STATE)
		|=> prdata[5:4] != 2'b11)
		else $error("window position shows the reserved code");

	a_state_raw: assert property ( // RQ16
		rd_setup && !pwrite && paddr == byte_addr(`IDX_COMPARATOR_STATE)
		|=> prdata[1:0] == $past(cmp_output_state))
		else $error("comparator state bits differ from comparator outputs");

	a_ready_read: assert property ( // RQ17
		rd_setup && !pwrite && paddr == byte_addr(`IDX_CMP_READY_STATUS)
		|=> prdata[1:0] == $past(cmp_output_valid))
		else $error("ready bits differ from comparator ready levels");

	a_win_outside: assert property ( // RQ18
		pos == WIN_INSIDE && state_reg.win_sel == 2'h3 |-> !win_hit)
		else $error("outside selection hit while inside the window");

	// Bus answer shape
	a_pready_pulse: assert property (
		pready |=> !pready)
		else $error("bus answer stands longer than one cycle");

	a_slverr_ready: assert property (
		pslverr |-> pready)
		else $error("bus error shown without an answer");

	c_flag_irq: cover property (state_reg.cmp_flag[1] && state_reg.cmp_ien[1] ##1 irq);
	c_win_event: cover property (window_event_out);
	c_start: cover property (cmp_start == 2'b11);
	c_set_clear_same: cover property (wr && paddr == byte_addr(`IDX_IRQ_FLAGS) && |hit);
	c_win_outside: cover property (state_reg.win_sel == 2'h3 && win_hit);

endmodule

// ---- include/cmp_regs_defines.svh ----
`ifndef CMP_REGS_DEFINES_SVH
`define CMP_REGS_DEFINES_SVH

// Register indices; byte address is four times the index
`define IDX_EVENT_CONTROL 8'h02
`define IDX_IRQ_ENABLE_CLEAR 8'h04
`define IDX_IRQ_ENABLE_SET 8'h05
`define IDX_IRQ_FLAGS 8'h06
`define IDX_COMPARATOR_STATE 8'h08
`define IDX_CMP_READY_STATUS 8'h09
`define IDX_UNIT_CONFIG 8'h10

// Shared bit positions of the enable and flag registers
`define BIT_CMP0 0
`define BIT_CMP1 1
`define BIT_WIN 4

// Event control fields
`define EVC_START_LSB 8
`define EVC_WIN_OUT_BIT 4

// Comparator state fields
`define STATE_WPOS_LSB 4

// Unit configuration fields
`define CFG_ENABLE_BIT 0
`define CFG_WIN_EN_BIT 1
`define CFG_WIN_SEL_LSB 2
`define CFG_CMP_SEL_LSB 4

// Reset values
`define RST_EVENT_CONTROL 16'h0000
`define RST_IRQ_ENABLE 8'h00
`define RST_IRQ_FLAGS 8'h00
`define RST_UNIT_CONFIG 8'h00

`endif

// ---- include/cmp_regs_pkg.sv ----
package cmp_regs_pkg;

	typedef enum logic [1:0] {
		CMP_IRQ_TOGGLE = 2'h0,
		CMP_IRQ_RISING = 2'h1,
		CMP_IRQ_FALLING = 2'h2,
		CMP_IRQ_DONE = 2'h3
	} cmp_irq_sel_t;

	typedef enum logic [1:0] {
		WIN_ABOVE = 2'h0,
		WIN_INSIDE = 2'h1,
		WIN_BELOW = 2'h2,
		WIN_OUTSIDE = 2'h3
	} win_code_t;

	typedef struct packed {
		logic [1:0] evt_start_en;
		logic win_evt_out_en;
		logic [1:0] evt_out_en;
		logic [1:0] cmp_ien;
		logic win_ien;
		logic [1:0] cmp_flag;
		logic win_flag;
		logic unit_en;
		logic win_en;
		logic [1:0] win_sel;
		logic [3:0] cmp_sel;
		logic [1:0] prev_out;
		logic [1:0] prev_ready;
		logic prev_win_hit;
		logic [1:0] start;
		logic [1:0] evt_out;
		logic win_evt;
		logic irq;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} regs_t;

endpackage

// ---- tb/cmp_core_model.sv ----
`timescale 1ns/10ps
module cmp_core_model #(
	parameter int LAT = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [1:0] start,
	input wire logic [1:0] level,
	output logic [1:0] state,
	output logic [1:0] valid
);
	int cnt [2];
	for (genvar i = 0; i < 2; i++) begin : g_cmp
		always @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				state[i] <= 1'b0;
				valid[i] <= 1'b0;
				cnt[i] <= 0;
			end else if (start[i]) begin
				valid[i] <= 1'b0;
				cnt[i] <= LAT;
			end else begin
				// Output not valid: line wanders
				if (cnt[i] == 1) begin
					valid[i] <= 1'b1;
					state[i] <= level[i];
				end else if (!valid[i]) begin
					state[i] <= ~state[i];
				end else begin
					// Continuous output follows its input while ready
					state[i] <= level[i];
				end
				if (cnt[i] != 0) cnt[i] <= cnt[i] - 1;
			end
		end
	end
endmodule

// ---- tb/tb_comparator_event_irq_status_regs.sv ----
`timescale 1ns/10ps
module tb_comparator_event_irq_status_regs;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic pready, pslverr, window_event_out, unit_enable, irq, rerr;
	logic wseen = 0, cseen = 0;
	logic [3:0] start_event_in = 4'h0;
	logic [1:0] cmp_output_state, cmp_output_valid, cmp_start, cmp_event_out;
	logic [1:0] level = 2'h0;
	logic [1:0] lv [3] = '{2'h1, 2'h2, 2'h0};
	int err_count = 0, n_tests = 0;
	always #20 pclk = ~pclk;
	always @(posedge pclk) begin
		if (window_event_out) wseen <= 1'b1;
		if (|cmp_event_out) cseen <= 1'b1;
	end
	comparator_event_irq_status_regs dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .start_event_in(start_event_in),
		.cmp_output_state(cmp_output_state), .cmp_output_valid(cmp_output_valid),
		.cmp_start(cmp_start), .cmp_event_out(cmp_event_out),
		.window_event_out(window_event_out), .unit_enable(unit_enable), .irq(irq));
	cmp_core_model core (.clk(pclk), .rst_n(presetn), .start(cmp_start), .level(level),
		.state(cmp_output_state), .valid(cmp_output_valid));
	task print_verdict;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 16) begin
			err_count++;
			print_verdict();
		end
		@(posedge pclk);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdat, exp);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task evt(input logic [1:0] exp);
		start_event_in <= 4'h4;
		@(posedge pclk);
		start_event_in <= 4'h0;
		#1 chk({30'h0, cmp_start}, {30'h0, exp});
	endtask
	task waitv;
		int i;
		// Let the start reach the model before looking at ready
		repeat (2) @(posedge pclk);
		for (i = 0; i < 32; i++) begin
			if (cmp_output_valid === 2'h3) break;
			@(posedge pclk);
		end
		if (i == 32) begin
			err_count++;
			print_verdict();
		end
		repeat (2) @(posedge pclk);
	endtask
	task setlv(input logic [1:0] v);
		level <= v;
		repeat (3) @(posedge pclk);
	endtask
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(8'h10, 32'h0);
		rd(8'h18, 32'h0);
		wr(8'h14, 32'h13);
		rd(8'h10, 32'h13);
		chk({31'h0, rerr}, 32'h0);
		wr(8'h10, 32'h01);
		rd(8'h14, 32'h12);
		wr(8'h14, 32'h0);
		rd(8'h10, 32'h12);
		rd(8'h0C, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		wr(8'h08, 32'h313);
		rd(8'h08, 32'h313);
		wr(8'h40, 32'hF1);
		chk({31'h0, unit_enable}, 32'h1);
		wr(8'h08, 32'h0);
		rd(8'h08, 32'h313);
		$display("end: enables and locking");
		evt(2'h3);
		waitv();
		rd(8'h18, 32'h03);
		chk({31'h0, irq}, 32'h1);
		chk({31'h0, cseen}, 32'h1);
		rd(8'h24, 32'h03);
		wr(8'h18, 32'h02);
		rd(8'h18, 32'h01);
		chk({31'h0, irq}, 32'h0);
		wr(8'h18, 32'h01);
		$display("end: comparator flags");
		wr(8'h40, 32'hF7);
		for (int k = 0; k < 3; k++) begin
			level <= lv[k];
			evt(2'h3);
			waitv();
			rd(8'h20, (32'(k) << 4) | 32'(lv[k]));
			rd(8'h18, (k == 1) ? 32'h13 : 32'h03);
			wr(8'h18, 32'h13);
			rd(8'h18, 32'h0);
		end
		chk({31'h0, wseen}, 32'h1);
		$display("end: window");
		wr(8'h40, 32'h9F);
		setlv(2'h3);
		rd(8'h18, 32'h11);
		setlv(2'h0);
		rd(8'h18, 32'h13);
		wr(8'h18, 32'h13);
		wr(8'h40, 32'h03);
		setlv(2'h1);
		rd(8'h18, 32'h11);
		$display("end: edge and window selections");
		wr(8'h40, 32'h0);
		chk({31'h0, unit_enable}, 32'h0);
		wr(8'h08, 32'h0003);
		evt(2'h0);
		$display("end: start disabled");
		print_verdict();
	end
endmodule
